/* hdl/latch_channel.sv */
// one channel: output latch with set and clear strobes
// assumes strobes are one-cycle pulses from the top-level decode
`timescale 1ns/1ps
module latch_channel (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       set_stb,
    input  wire logic       clr_stb,
    input  wire logic [7:0] wdata,
    output logic      [7:0] latch_q
);
    logic [7:0] latch_d;

    // the two strobes come from distinct addresses, so they never coincide
    assign latch_d = set_stb ? (latch_q | wdata) :
                     clr_stb ? (latch_q & ~wdata) : latch_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= opl_pkg::LATCH_RESET;
        end else begin
            latch_q <= latch_d;
        end
    end

    property p_set_bits;
        @(posedge clk_sys) disable iff (!rst_n)
        set_stb |=> (latch_q == ($past(latch_q) | $past(wdata)));
    endproperty
    a_set_bits: assert property (p_set_bits) else $error("set write wrong");

    property p_clr_bits;
        @(posedge clk_sys) disable iff (!rst_n)
        clr_stb |=> (latch_q == ($past(latch_q) & ~$past(wdata)));
    endproperty
    a_clr_bits: assert property (p_clr_bits) else $error("clear write wrong");

    property p_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (!set_stb && !clr_stb) |=> $stable(latch_q);
    endproperty
    a_hold: assert property (p_hold) else $error("latch moved without write");
endmodule

/* hdl/opl_pkg.sv */
// constants and carrier types for the port A/B output latch block
// assumes a byte-wide host register bus with a 7-bit address and a one-cycle write strobe
// Behaviour
// - a write to a channel's set register forces to one every latch bit written as one.
// - a write to a channel's clear register forces to zero every latch bit written as one.
// - channels A and B each own a set register, clear register and latch, never crossing.
// - a pin enabled for latch output is driven at the inverse of its latch bit.
// - a pin shows its inverted latch bit only while its two-bit configuration code is 01.
// - the latch cannot be read back and changes only through set and clear writes.
// - the pin configuration registers reset to zero, so every pin starts as an input.
// - code 00 only disables the output driver; the input path stays active always.
package opl_pkg;
    localparam logic [6:0] ADDR_SET_A   = 7'h10;
    localparam logic [6:0] ADDR_CLR_A   = 7'h11;
    localparam logic [6:0] ADDR_CFG0    = 7'h13;
    localparam logic [6:0] ADDR_CFG1    = 7'h14;
    localparam logic [6:0] ADDR_SET_B   = 7'h18;
    localparam logic [6:0] ADDR_CLR_B   = 7'h19;
    localparam logic [6:0] ADDR_CFG2    = 7'h1B;
    localparam logic [6:0] ADDR_CFG3    = 7'h1C;
    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] LATCH_RESET  = 8'h00;
    localparam logic [1:0] CODE_LATCH   = 2'h1;
    localparam logic [1:0] CODE_INPUT   = 2'h0;

    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } host_wr_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_t;
endpackage

/* hdl/output_port_set_clear.sv */
// output latches and pin drive for I/O ports A and B
// assumes host write signals synchronous to clk_sys; pins resolved outside from oe
`timescale 1ns/1ps
module output_port_set_clear (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       host_wr,
    input  wire logic [6:0] host_addr,
    input  wire logic [7:0] host_wdata,
    input  wire logic [7:0] pin_in_a,
    input  wire logic [7:0] pin_in_b,
    output logic      [7:0] pin_out_a,
    output logic      [7:0] pin_oe_a,
    output logic      [7:0] pin_out_b,
    output logic      [7:0] pin_oe_b,
    output logic      [7:0] pin_level_a,
    output logic      [7:0] pin_level_b
);
    logic [1:0]  rst_sync_q;
    logic        rst_n;
    opl_pkg::host_wr_t req;
    logic [7:0]  cfg0_q, cfg1_q, cfg2_q, cfg3_q;
    logic [7:0]  latch_a, latch_b;
    logic        set_a, clr_a, set_b, clr_b;
    logic [15:0] code_a, code_b;
    opl_pkg::pin_drive_t drv_a, drv_b;

    function automatic opl_pkg::pin_drive_t drive(input logic [15:0] code,
                                                  input logic [7:0]  latch);
        opl_pkg::pin_drive_t r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r.oe[i]  = (code[2*i +: 2] == opl_pkg::CODE_LATCH);
            r.out[i] = r.oe[i] & ~latch[i];
        end
        return r;
    endfunction

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign req   = '{wr: host_wr, addr: host_addr, data: host_wdata};
    assign set_a = req.wr && (req.addr == opl_pkg::ADDR_SET_A);
    assign clr_a = req.wr && (req.addr == opl_pkg::ADDR_CLR_A);
    assign set_b = req.wr && (req.addr == opl_pkg::ADDR_SET_B);
    assign clr_b = req.wr && (req.addr == opl_pkg::ADDR_CLR_B);

    latch_channel u_chan_a (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .set_stb (set_a),
        .clr_stb (clr_a),
        .wdata   (req.data),
        .latch_q (latch_a)
    );

    latch_channel u_chan_b (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .set_stb (set_b),
        .clr_stb (clr_b),
        .wdata   (req.data),
        .latch_q (latch_b)
    );

    // config registers are write-only here; read paths belong to the wider register file
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg0_q <= opl_pkg::CFG_RESET;
            cfg1_q <= opl_pkg::CFG_RESET;
            cfg2_q <= opl_pkg::CFG_RESET;
            cfg3_q <= opl_pkg::CFG_RESET;
        end else if (req.wr) begin
            if (req.addr == opl_pkg::ADDR_CFG0) cfg0_q <= req.data;
            if (req.addr == opl_pkg::ADDR_CFG1) cfg1_q <= req.data;
            if (req.addr == opl_pkg::ADDR_CFG2) cfg2_q <= req.data;
            if (req.addr == opl_pkg::ADDR_CFG3) cfg3_q <= req.data;
        end
    end

    assign code_a = {cfg1_q, cfg0_q};
    assign code_b = {cfg3_q, cfg2_q};
    assign drv_a  = drive(code_a, latch_a);
    assign drv_b  = drive(code_b, latch_b);

    // one register stage keeps every output on a flip-flop; pins lag the latch by a cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_a   <= 8'h00;
            pin_oe_a    <= 8'h00;
            pin_out_b   <= 8'h00;
            pin_oe_b    <= 8'h00;
            pin_level_a <= 8'h00;
            pin_level_b <= 8'h00;
        end else begin
            pin_out_a   <= drv_a.out;
            pin_oe_a    <= drv_a.oe;
            pin_out_b   <= drv_b.out;
            pin_oe_b    <= drv_b.oe;
            pin_level_a <= pin_in_a;
            pin_level_b <= pin_in_b;
        end
    end

    property p_pin_inverse_a;
        @(posedge clk_sys) disable iff (!rst_n)
        (code_a[1:0] == 2'h1) |=> (pin_oe_a[0] && pin_out_a[0] == !$past(latch_a[0]));
    endproperty
    a_pin_inverse_a: assert property (p_pin_inverse_a) else $error("pin A0 not inverse");

    property p_oe_code_b;
        @(posedge clk_sys) disable iff (!rst_n)
        (code_b[3:2] != 2'h1) |=> !pin_oe_b[1];
    endproperty
    a_oe_code_b: assert property (p_oe_code_b) else $error("pin B1 driven off code");

    property p_chan_isolate;
        @(posedge clk_sys) disable iff (!rst_n)
        (set_a || clr_a) |=> $stable(latch_b);
    endproperty
    a_chan_isolate: assert property (p_chan_isolate) else $error("A write moved B");

    property p_input_follow;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> (pin_level_b == $past(pin_in_b));
    endproperty
    a_input_follow: assert property (p_input_follow) else $error("input path lost");

    property p_cfg_reset;
        @(posedge clk_sys) $rose(rst_n) |-> (code_a == 16'h0000 && code_b == 16'h0000);
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config not zero at reset");

    property p_pin_inverse_b;
        @(posedge clk_sys) disable iff (!rst_n)
        (code_b[1:0] == opl_pkg::CODE_LATCH) |=> (pin_oe_b[0] && pin_out_b[0] == !$past(latch_b[0]));
    endproperty
    a_pin_inverse_b: assert property (p_pin_inverse_b) else $error("pin B0 not inverse");

    property p_pin_inverse_a7;
        @(posedge clk_sys) disable iff (!rst_n)
        (code_a[15:14] == opl_pkg::CODE_LATCH) |=> (pin_oe_a[7] && pin_out_a[7] == !$past(latch_a[7]));
    endproperty
    a_pin_inverse_a7: assert property (p_pin_inverse_a7) else $error("pin A7 not inverse");

    property p_pin_inverse_b6;
        @(posedge clk_sys) disable iff (!rst_n)
        (code_b[13:12] == opl_pkg::CODE_LATCH) |=> (pin_oe_b[6] && pin_out_b[6] == !$past(latch_b[6]));
    endproperty
    a_pin_inverse_b6: assert property (p_pin_inverse_b6) else $error("pin B6 not inverse");

    property p_oe_code_a;
        @(posedge clk_sys) disable iff (!rst_n)
        (code_a[1:0] != opl_pkg::CODE_LATCH) |=> !pin_oe_a[0];
    endproperty
    a_oe_code_a: assert property (p_oe_code_a) else $error("pin A0 driven off code");

    // code 00 leaves the pin floating, the input copy still tracks it
    property p_idle_a;
        @(posedge clk_sys) disable iff (!rst_n)
        (code_a[3:2] == opl_pkg::CODE_INPUT) |=> (!pin_oe_a[1] && !pin_out_a[1]);
    endproperty
    a_idle_a: assert property (p_idle_a) else $error("pin A1 driven at code 00");

    property p_chan_isolate_b;
        @(posedge clk_sys) disable iff (!rst_n)
        (set_b || clr_b) |=> $stable(latch_a);
    endproperty
    a_chan_isolate_b: assert property (p_chan_isolate_b) else $error("B write moved A");

    property p_input_follow_a;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> (pin_level_a == $past(pin_in_a));
    endproperty
    a_input_follow_a: assert property (p_input_follow_a) else $error("input path A lost");

    property p_out_gated_a;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |-> ((pin_out_a & ~pin_oe_a) == 8'h00);
    endproperty
    a_out_gated_a: assert property (p_out_gated_a) else $error("A drive without enable");

    property p_out_gated_b;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |-> ((pin_out_b & ~pin_oe_b) == 8'h00);
    endproperty
    a_out_gated_b: assert property (p_out_gated_b) else $error("B drive without enable");

    // configuration only moves on a host write
    property p_cfg_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !req.wr |=> ($stable(code_a) && $stable(code_b));
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config moved without write");

    property p_oe_follow_a;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> (pin_oe_a[3] == ($past(code_a[7:6]) == opl_pkg::CODE_LATCH));
    endproperty
    a_oe_follow_a: assert property (p_oe_follow_a) else $error("pin A3 enable wrong");

    property p_oe_follow_b;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> (pin_oe_b[2] == ($past(code_b[5:4]) == opl_pkg::CODE_LATCH));
    endproperty
    a_oe_follow_b: assert property (p_oe_follow_b) else $error("pin B2 enable wrong");

    property p_out_follow_a;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> (pin_out_a[5] ==
                  ($past(code_a[11:10]) == opl_pkg::CODE_LATCH && !$past(latch_a[5])));
    endproperty
    a_out_follow_a: assert property (p_out_follow_a) else $error("pin A5 level wrong");

    // latch zero after reset so a later enable starts high
    property p_latch_reset;
        @(posedge clk_sys)
        $rose(rst_n) |-> (latch_a == opl_pkg::LATCH_RESET && latch_b == opl_pkg::LATCH_RESET);
    endproperty
    a_latch_reset: assert property (p_latch_reset) else $error("latch not clear at reset");

    property p_pin_reset;
        @(posedge clk_sys)
        $rose(rst_n) |-> (pin_oe_a == 8'h00 && pin_oe_b == 8'h00);
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pins driven at reset");
endmodule

/* testbench/pin_load.sv */
// pull-up load on one 8-pin port, resolving each wire from the enables
// assumes one instance per port; a released pin reads high
`timescale 1ns/1ps
module pin_load (
    input  wire logic [7:0] drv,
    input  wire logic [7:0] oe,
    output logic      [7:0] level
);
    // released pins go to the pull-up level, never a held value
    assign level = (drv & oe) | ~oe;
endmodule

/* testbench/tb_output_port_set_clear.sv */
// self-checking bench for the port A/B output latch block
// assumes pull-up loads on all pins; inputs change on the falling edge
`timescale 1ns/1ps
module tb_output_port_set_clear;
    logic       clk_sys    = 1'b0;
    logic       arst_n     = 1'b1;
    logic       host_wr    = 1'b0;
    logic [6:0] host_addr  = 7'h00;
    logic [7:0] host_wdata = 8'h00;
    logic [7:0] pin_in_a, pin_in_b, pin_out_a, pin_oe_a, pin_out_b, pin_oe_b;
    logic [7:0] pin_level_a, pin_level_b;
    int         miscompares = 0;
    int         checks_done = 0;
    int         cycles      = 0;
    always #10 clk_sys = ~clk_sys;
    output_port_set_clear output_port_set_clear_i (
        .clk_sys(clk_sys), .arst_n(arst_n), .host_wr(host_wr),
        .host_addr(host_addr), .host_wdata(host_wdata),
        .pin_in_a(pin_in_a), .pin_in_b(pin_in_b),
        .pin_out_a(pin_out_a), .pin_oe_a(pin_oe_a),
        .pin_out_b(pin_out_b), .pin_oe_b(pin_oe_b),
        .pin_level_a(pin_level_a), .pin_level_b(pin_level_b));
    pin_load pin_load_a_i (.drv(pin_out_a), .oe(pin_oe_a), .level(pin_in_a));
    pin_load pin_load_b_i (.drv(pin_out_b), .oe(pin_oe_b), .level(pin_in_b));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        host_wr = 1'b1;
        host_addr = a;
        host_wdata = d;
        @(negedge clk_sys);
        host_wr = 1'b0;
    endtask
    // pins follow a write two edges later; three leaves margin
    task automatic settle;
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic stop_test;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_reset;
        check(pin_oe_a | pin_oe_b, 8'h00);
        check(pin_level_a & pin_level_b, 8'hFF);
    endtask
    task automatic t_latch_a;
        wr(7'h13, 8'h55);
        wr(7'h14, 8'h55);
        settle();
        check(pin_oe_a, 8'hFF);
        check(pin_out_a, 8'hFF);
        wr(7'h10, 8'hA5);
        settle();
        check(pin_out_a, 8'h5A);
        wr(7'h11, 8'h81);
        wr(7'h10, 8'h00);
        settle();
        check(pin_level_a, 8'hDB);
        check(pin_oe_b, 8'h00);
    endtask
    task automatic t_chan_b;
        wr(7'h1B, 8'h1D);
        wr(7'h18, 8'hFF);
        wr(7'h12, 8'hFF);
        settle();
        check(pin_oe_b, 8'h05);
        check(pin_level_b, 8'hFA);
        check(pin_out_a, 8'hDB);
        wr(7'h19, 8'h04);
        settle();
        check(pin_out_b, 8'h04);
        check(pin_level_b, 8'hFE);
    endtask
    task automatic t_disable;
        wr(7'h13, 8'h00);
        wr(7'h14, 8'h00);
        settle();
        check(pin_oe_a, 8'h00);
        check(pin_level_a, 8'hFF);
        wr(7'h13, 8'h55);
        wr(7'h14, 8'h55);
        settle();
        check(pin_out_a, 8'hDB);
    endtask
    // mid-run reset must wipe the latch and the configuration again
    task automatic t_mid_reset;
        @(negedge clk_sys);
        arst_n = 1'b0;
        @(negedge clk_sys);
        check(pin_oe_a | pin_oe_b, 8'h00);
        arst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(pin_oe_a, 8'h00);
        wr(7'h13, 8'h55);
        wr(7'h14, 8'h55);
        settle();
        check(pin_out_a, 8'hFF);
        check(pin_oe_b, 8'h00);
    endtask
    // ceiling well above the roughly 80 cycles the tasks need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        // a real falling edge, so the asynchronous clears fire
        #1 arst_n = 1'b0;
        repeat (20) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_reset();
        t_latch_a();
        t_chan_b();
        t_disable();
        t_mid_reset();
        stop_test();
    end
endmodule
